// ===== logic/tmr_defs.svh
// Constants shared by the reload timer pair: codes, limits and reset values.
// Assumes it is included by its bare name from every design file that needs it.
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define DIV12_LAST   4'hB
`define DIV8_LAST    3'h7
`define PRE_RESET    4'h0
`define DIV_RESET    3'h0
`define SYNC_RESET   8'hE0
`define BYTE_RESET   8'h00
`define WORD_RESET   16'h0000
`define BYTE_MAX     8'hFF
`define WORD_MAX     16'hFFFF
`define BYTE_ONE     8'h01
`define WORD_ONE     16'h0001
`define XSEL_DIV12   2'h0
`define XSEL_SRC01   2'h1
`define XSEL_SRC11   2'h3
`define XSEL_CAP_BIT 1
`define LOW_BYTE     7:0
`define HIGH_BYTE    15:8

`endif

// ===== logic/tmr_pkg.sv
// Types of the reload timer pair: write targets and the state of the timer top and of each pin synchroniser.
// Assumes nothing of its surroundings.
package tmr_pkg;

    typedef enum logic [2:0] {
        WR_A_CNT_L,
        WR_A_CNT_H,
        WR_A_RLD_L,
        WR_A_RLD_H,
        WR_B_CNT_L,
        WR_B_CNT_H,
        WR_B_RLD_L,
        WR_B_RLD_H
    } wr_target_t;

    typedef struct packed {
        logic [3:0]  pre;
        logic        div12;
        logic [15:0] a_count;
        logic [15:0] a_reload;
        logic        a_flag_h;
        logic        a_irq;
        logic [15:0] b_count;
        logic [15:0] b_reload;
        logic        b_flag_h;
        logic        b_flag_l;
        logic        b_irq;
    } top_state_t;

    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       s3;
        logic [2:0] div;
        logic       rise;
        logic       div8;
    } sync_state_t;

endpackage

// ===== logic/tick_if.sv
// Count-enable pulses shared between the timer top and its clock selectors.
// Assumes every signal is a one-cycle pulse on the system clock.
`timescale 1ns/10ps

interface tick_if;
    logic div12;
    logic cmp_rise;
    logic rtc_rise;
    logic rtc_div8;
    logic ext_div8;

    modport prod (output div12, output cmp_rise, output rtc_rise, output rtc_div8,
                  output ext_div8);
    modport cons (input div12, input cmp_rise, input rtc_rise, input rtc_div8,
                  input ext_div8);
endinterface

// ===== logic/pin_sync.sv
// Synchroniser for one asynchronous clock pin: rising-edge pulse and divide-by-8 pulse.
// Assumes the pin toggles slower than half the system clock rate.
`timescale 1ns/10ps
`include "tmr_defs.svh"

module pin_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic pin,
    output wire logic rise,
    output wire logic div8_tick
);
    tmr_pkg::sync_state_t s;
    tmr_pkg::sync_state_t n;

    always_comb begin
        n = s;
        if (ce) begin
            n.s1   = pin;
            n.s2   = s.s1;
            n.s3   = s.s2;
            n.rise = s.s2 && !s.s3;
            n.div8 = 1'b0;
            if (s.s2 && !s.s3) begin
                if (s.div == `DIV8_LAST) begin
                    n.div  = `DIV_RESET;
                    n.div8 = 1'b1;
                end else begin
                    n.div = s.div + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        // The three stages reset high, so a pin that is already high at release gives no edge.
        if (!nrst) begin
            s <= tmr_pkg::sync_state_t'(`SYNC_RESET);
        end else begin
            s <= n;
        end
    end

    assign rise      = s.rise;
    assign div8_tick = s.div8;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_rise_from_pin: assert property (
        rise && $past(ce, 1) && $past(ce, 2) && $past(ce, 3) && $past(ce, 4)
        |-> $past(pin, 3) && !$past(pin, 4))
        else $error("Edge pulse without a matching pin rise.");

    a_div8_spacing: assert property (
        disable iff (!nrst || !ce)
        div8_tick |=> !div8_tick [*8])
        else $error("Divide-by-8 pulses too close together.");
endmodule

// ===== logic/clock_select.sv
// Count-enable selector for one timer or one split timer B byte: system clock or the external choice.
// Assumes the tick pulses arrive already synchronised to the system clock.
`timescale 1ns/10ps
`include "tmr_defs.svh"

module clock_select #(
    parameter logic TIMER_B = 1'b0
) (
    tick_if.cons      ticks,
    input  wire logic system_clock_sel,
    input  wire logic [1:0] ext_sel,
    output logic      tick
);
    // Timer A takes the rtc oscillator divided by 8 and the comparator; timer B the
    // rtc oscillator edge itself and the external oscillator divided by 8.
    always_comb begin
        if (system_clock_sel) begin
            tick = 1'b1;
        end else if (ext_sel == `XSEL_DIV12) begin
            tick = ticks.div12;
        end else if (ext_sel == `XSEL_SRC01) begin
            tick = TIMER_B ? ticks.rtc_rise : ticks.rtc_div8;
        end else if (ext_sel == `XSEL_SRC11) begin
            tick = TIMER_B ? ticks.ext_div8 : ticks.cmp_rise;
        end else begin
            tick = 1'b0;
        end
    end
endmodule

// ===== logic/reload_timer_pair.sv
// Two 16-bit auto-reload timers with period capture, software facing plain ports.
// Assumes control inputs come from logic on clk; comparator and oscillator pins are async.
`timescale 1ns/10ps
`include "tmr_defs.svh"

module reload_timer_pair (
    input  wire logic                clk,
    input  wire logic                nrst,
    input  wire logic                ce,
    input  wire logic                comparator0,
    input  wire logic                rtc_osc,
    input  wire logic                ext_osc,
    input  wire logic                wr_en,
    input  wire tmr_pkg::wr_target_t wr_target,
    input  wire logic [7:0]          wr_data,
    input  wire logic                tmr_a_run,
    input  wire logic                tmr_a_capture_enable,
    input  wire logic [1:0]          tmr_a_ext_clock_select,
    input  wire logic                tmr_a_low_system_clock_select,
    input  wire logic                tmr_a_irq_enable,
    input  wire logic                tmr_a_flag_clear,
    input  wire logic                tmr_b_run,
    input  wire logic                tmr_b_split_mode,
    input  wire logic                tmr_b_capture_enable,
    input  wire logic [1:0]          tmr_b_ext_clock_select,
    input  wire logic                tmr_b_high_system_clock_select,
    input  wire logic                tmr_b_low_system_clock_select,
    input  wire logic                tmr_b_low_irq_enable,
    input  wire logic                extended_irq_enable_one,
    input  wire logic                tmr_b_high_flag_clear,
    input  wire logic                tmr_b_low_flag_clear,
    output wire logic [7:0]          tmr_a_count_high,
    output wire logic [7:0]          tmr_a_count_low,
    output wire logic [7:0]          tmr_a_reload_high,
    output wire logic [7:0]          tmr_a_reload_low,
    output wire logic                tmr_a_high_overflow_flag,
    output wire logic                tmr_a_irq,
    output wire logic [7:0]          tmr_b_count_high,
    output wire logic [7:0]          tmr_b_count_low,
    output wire logic [7:0]          tmr_b_reload_high,
    output wire logic [7:0]          tmr_b_reload_low,
    output wire logic                tmr_b_high_overflow_flag,
    output wire logic                tmr_b_low_overflow_flag,
    output wire logic                tmr_b_irq
);
    tmr_pkg::top_state_t s;
    tmr_pkg::top_state_t n;

    logic cmp_rise;
    logic rtc_rise;
    logic rtc_div8;
    logic ext_div8;
    logic a_tick;
    logic b_tick_l;
    logic b_tick_h;
    logic cap_a;
    logic cap_b;
    logic a_set;
    logic b_set_h;
    logic b_set_l;

    tick_if ticks ();

    pin_sync cmp_sync (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .pin       (comparator0),
        .rise      (cmp_rise),
        .div8_tick ()
    );

    pin_sync rtc_sync (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .pin       (rtc_osc),
        .rise      (rtc_rise),
        .div8_tick (rtc_div8)
    );

    pin_sync ext_sync (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .pin       (ext_osc),
        .rise      (),
        .div8_tick (ext_div8)
    );

    assign ticks.div12    = s.div12;
    assign ticks.cmp_rise = cmp_rise;
    assign ticks.rtc_rise = rtc_rise;
    assign ticks.rtc_div8 = rtc_div8;
    assign ticks.ext_div8 = ext_div8;

    clock_select #(.TIMER_B(1'b0)) a_sel (
        .ticks      (ticks),
        .system_clock_sel (tmr_a_low_system_clock_select),
        .ext_sel    (tmr_a_ext_clock_select),
        .tick       (a_tick)
    );

    clock_select #(.TIMER_B(1'b1)) b_low_sel (
        .ticks      (ticks),
        .system_clock_sel (tmr_b_low_system_clock_select),
        .ext_sel    (tmr_b_ext_clock_select),
        .tick       (b_tick_l)
    );

    clock_select #(.TIMER_B(1'b1)) b_high_sel (
        .ticks      (ticks),
        .system_clock_sel (tmr_b_high_system_clock_select),
        .ext_sel    (tmr_b_ext_clock_select),
        .tick       (b_tick_h)
    );

    assign cap_a = tmr_a_capture_enable &&
        (tmr_a_ext_clock_select[`XSEL_CAP_BIT] ? cmp_rise : rtc_div8);
    assign cap_b = tmr_b_capture_enable &&
        (tmr_b_ext_clock_select[`XSEL_CAP_BIT] ? ext_div8 : rtc_rise);

    always_comb begin
        n       = s;
        a_set   = 1'b0;
        b_set_h = 1'b0;
        b_set_l = 1'b0;
        if (ce) begin
            if (s.pre == `DIV12_LAST) begin
                n.pre   = `PRE_RESET;
                n.div12 = 1'b1;
            end else begin
                n.pre   = s.pre + 4'h1;
                n.div12 = 1'b0;
            end

            // While capturing, a wrap runs freely so captured differences stay valid.
            if (a_tick && tmr_a_run) begin
                if (s.a_count == `WORD_MAX) begin
                    if (tmr_a_capture_enable) begin
                        n.a_count = `WORD_RESET;
                    end else begin
                        n.a_count = s.a_reload;
                        a_set     = 1'b1;
                    end
                end else begin
                    n.a_count = s.a_count + `WORD_ONE;
                end
            end

            if (!tmr_b_split_mode) begin
                if (b_tick_l && tmr_b_run) begin
                    if (s.b_count[`LOW_BYTE] == `BYTE_MAX && !tmr_b_capture_enable) begin
                        b_set_l = 1'b1;
                    end
                    if (s.b_count == `WORD_MAX) begin
                        if (tmr_b_capture_enable) begin
                            n.b_count = `WORD_RESET;
                        end else begin
                            n.b_count = s.b_reload;
                            b_set_h   = 1'b1;
                        end
                    end else begin
                        n.b_count = s.b_count + `WORD_ONE;
                    end
                end
            end else begin
                if (b_tick_l) begin
                    if (s.b_count[`LOW_BYTE] == `BYTE_MAX) begin
                        n.b_count[`LOW_BYTE] = s.b_reload[`LOW_BYTE];
                        b_set_l              = 1'b1;
                    end else begin
                        n.b_count[`LOW_BYTE] = s.b_count[`LOW_BYTE] + `BYTE_ONE;
                    end
                end
                if (b_tick_h && tmr_b_run) begin
                    if (s.b_count[`HIGH_BYTE] == `BYTE_MAX) begin
                        n.b_count[`HIGH_BYTE] = s.b_reload[`HIGH_BYTE];
                        b_set_h               = 1'b1;
                    end else begin
                        n.b_count[`HIGH_BYTE] = s.b_count[`HIGH_BYTE] + `BYTE_ONE;
                    end
                end
            end

            // A software write replaces the byte it names, over any count step.
            if (wr_en) begin
                case (wr_target)
                    tmr_pkg::WR_A_CNT_L: n.a_count[`LOW_BYTE]   = wr_data;
                    tmr_pkg::WR_A_CNT_H: n.a_count[`HIGH_BYTE]  = wr_data;
                    tmr_pkg::WR_A_RLD_L: n.a_reload[`LOW_BYTE]  = wr_data;
                    tmr_pkg::WR_A_RLD_H: n.a_reload[`HIGH_BYTE] = wr_data;
                    tmr_pkg::WR_B_CNT_L: n.b_count[`LOW_BYTE]   = wr_data;
                    tmr_pkg::WR_B_CNT_H: n.b_count[`HIGH_BYTE]  = wr_data;
                    tmr_pkg::WR_B_RLD_L: n.b_reload[`LOW_BYTE]  = wr_data;
                    tmr_pkg::WR_B_RLD_H: n.b_reload[`HIGH_BYTE] = wr_data;
                    default: ;
                endcase
            end

            // A capture overrides a reload write in the same cycle.
            if (cap_a) begin
                n.a_reload = s.a_count;
                a_set      = 1'b1;
            end
            if (cap_b) begin
                n.b_reload = s.b_count;
                b_set_h    = 1'b1;
            end

            // A flag set in the cycle of its clear survives the clear.
            if (tmr_a_flag_clear) begin
                n.a_flag_h = 1'b0;
            end
            if (a_set) begin
                n.a_flag_h = 1'b1;
            end
            if (tmr_b_high_flag_clear) begin
                n.b_flag_h = 1'b0;
            end
            if (b_set_h) begin
                n.b_flag_h = 1'b1;
            end
            if (tmr_b_low_flag_clear) begin
                n.b_flag_l = 1'b0;
            end
            if (b_set_l) begin
                n.b_flag_l = 1'b1;
            end

            n.a_irq = tmr_a_irq_enable && n.a_flag_h;
            n.b_irq = extended_irq_enable_one &&
                (n.b_flag_h || (tmr_b_low_irq_enable && n.b_flag_l));
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign tmr_a_count_high         = s.a_count[`HIGH_BYTE];
    assign tmr_a_count_low          = s.a_count[`LOW_BYTE];
    assign tmr_a_reload_high        = s.a_reload[`HIGH_BYTE];
    assign tmr_a_reload_low         = s.a_reload[`LOW_BYTE];
    assign tmr_a_high_overflow_flag = s.a_flag_h;
    assign tmr_a_irq                = s.a_irq;
    assign tmr_b_count_high         = s.b_count[`HIGH_BYTE];
    assign tmr_b_count_low          = s.b_count[`LOW_BYTE];
    assign tmr_b_reload_high        = s.b_reload[`HIGH_BYTE];
    assign tmr_b_reload_low         = s.b_reload[`LOW_BYTE];
    assign tmr_b_high_overflow_flag = s.b_flag_h;
    assign tmr_b_low_overflow_flag  = s.b_flag_l;
    assign tmr_b_irq                = s.b_irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence a_cap_seq;
        ce && cap_a;
    endsequence

    sequence b_wrap_seq;
        ce && !tmr_b_split_mode && !tmr_b_capture_enable && b_tick_l && tmr_b_run
        && s.b_count == `WORD_MAX && !wr_en;
    endsequence

    sequence split_step_seq;
        ce && tmr_b_split_mode && !wr_en;
    endsequence

    a_capture_copy: assert property (
        a_cap_seq |=> s.a_reload == $past(s.a_count) && s.a_flag_h)
        else $error("Timer A capture did not copy the count.");

    a_reload_hold: assert property (
        ce && !tmr_a_capture_enable && !(wr_en && (wr_target == tmr_pkg::WR_A_RLD_L
        || wr_target == tmr_pkg::WR_A_RLD_H)) |=> $stable(s.a_reload))
        else $error("Timer A reload changed without capture or write.");

    a_b_wrap_reload: assert property (
        b_wrap_seq |=> s.b_count == $past(s.b_reload) && s.b_flag_h)
        else $error("Timer B wrap did not reload and flag.");

    a_b_low_irq: assert property (
        ce && extended_irq_enable_one && tmr_b_low_irq_enable && s.b_flag_l
        && !tmr_b_low_flag_clear |=> s.b_irq)
        else $error("Timer B low flag raised no interrupt.");

    a_split_high_gate: assert property (
        split_step_seq and (!tmr_b_run) |=> $stable(s.b_count[`HIGH_BYTE]))
        else $error("Split high half counted while stopped.");

    a_split_low_free: assert property (
        split_step_seq and (!tmr_b_run && b_tick_l && s.b_count[`LOW_BYTE] != `BYTE_MAX)
        |=> s.b_count[`LOW_BYTE] == $past(s.b_count[`LOW_BYTE]) + `BYTE_ONE)
        else $error("Split low half did not count freely.");

    a_split_low_wrap: assert property (
        split_step_seq and (b_tick_l && s.b_count[`LOW_BYTE] == `BYTE_MAX)
        |=> s.b_count[`LOW_BYTE] == $past(s.b_reload[`LOW_BYTE]) && s.b_flag_l)
        else $error("Split low half wrap wrong.");

    a_split_high_wrap: assert property (
        split_step_seq and (tmr_b_run && b_tick_h && s.b_count[`HIGH_BYTE] == `BYTE_MAX)
        |=> s.b_count[`HIGH_BYTE] == $past(s.b_reload[`HIGH_BYTE]) && s.b_flag_h)
        else $error("Split high half wrap wrong.");

    a_flag_sticky: assert property (
        s.b_flag_h && !tmr_b_high_flag_clear |=> s.b_flag_h)
        else $error("Timer B high flag cleared by hardware.");

    a_b_capture_copy: assert property (
        ce && cap_b |=> s.b_reload == $past(s.b_count) && s.b_flag_h)
        else $error("Timer B capture did not copy the count.");
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the reload timer pair; it drives every port itself.
// Assumes the design files under logic/ are compiled first and clk runs at 100 MHz.
`timescale 1ns/10ps

module tb_top;
    logic                clk, nrst, ce, comparator0, rtc_osc, ext_osc, wr_en;
    tmr_pkg::wr_target_t wr_target;
    logic [7:0]          wr_data;
    logic                tmr_a_run, tmr_a_capture_enable, tmr_a_low_system_clock_select;
    logic                tmr_a_irq_enable, tmr_a_flag_clear, tmr_b_run, tmr_b_split_mode;
    logic                tmr_b_capture_enable, tmr_b_high_system_clock_select;
    logic                tmr_b_low_system_clock_select, tmr_b_low_irq_enable, extended_irq_enable_one;
    logic                tmr_b_high_flag_clear, tmr_b_low_flag_clear;
    logic [1:0]          tmr_a_ext_clock_select, tmr_b_ext_clock_select;
    logic [7:0]          tmr_a_count_high, tmr_a_count_low, tmr_a_reload_high, tmr_a_reload_low;
    logic [7:0]          tmr_b_count_high, tmr_b_count_low, tmr_b_reload_high, tmr_b_reload_low;
    logic                tmr_a_high_overflow_flag, tmr_a_irq, tmr_b_high_overflow_flag;
    logic                tmr_b_low_overflow_flag, tmr_b_irq;
    int                  mismatches, compares, cycles;
    logic [31:0]         seed = 32'h93D8;
    logic [7:0]          pin_cnt = 8'h00;
    logic [15:0]         r1, c0, c1, caps[$];
    int                  ea[5] = '{16, 3, 0, 12, 192};
    int                  eb[5] = '{16, 24, 0, 6, 192};
    int                  per[4] = '{64, 16, 8, 32};

    reload_timer_pair uut (.clk, .nrst, .ce, .comparator0, .rtc_osc, .ext_osc, .wr_en,
        .wr_target, .wr_data, .tmr_a_run, .tmr_a_capture_enable, .tmr_a_ext_clock_select,
        .tmr_a_low_system_clock_select, .tmr_a_irq_enable, .tmr_a_flag_clear, .tmr_b_run,
        .tmr_b_split_mode, .tmr_b_capture_enable, .tmr_b_ext_clock_select,
        .tmr_b_high_system_clock_select, .tmr_b_low_system_clock_select, .tmr_b_low_irq_enable,
        .extended_irq_enable_one, .tmr_b_high_flag_clear, .tmr_b_low_flag_clear,
        .tmr_a_count_high, .tmr_a_count_low, .tmr_a_reload_high, .tmr_a_reload_low,
        .tmr_a_high_overflow_flag, .tmr_a_irq, .tmr_b_count_high, .tmr_b_count_low,
        .tmr_b_reload_high, .tmr_b_reload_low, .tmr_b_high_overflow_flag,
        .tmr_b_low_overflow_flag, .tmr_b_irq);

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Pins run free: ext period 4, rtc period 8, comparator period 16 cycles.
    assign ext_osc     = pin_cnt[1];
    assign rtc_osc     = pin_cnt[2];
    assign comparator0 = pin_cnt[3];

    always @(posedge clk) begin
        #1 pin_cnt = pin_cnt + 8'h01;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    function automatic logic [7:0] rnd();
        logic [31:0] v;
        v = seed ^ (seed << 13);
        v = v ^ (v >> 17);
        seed = v ^ (v << 5);
        return seed[7:0];
    endfunction

    function automatic logic [15:0] cnt(input bit b);
        return b ? {tmr_b_count_high, tmr_b_count_low} : {tmr_a_count_high, tmr_a_count_low};
    endfunction

    function automatic logic [15:0] rld(input bit b);
        return b ? {tmr_b_reload_high, tmr_b_reload_low} : {tmr_a_reload_high, tmr_a_reload_low};
    endfunction

    function automatic logic flag(input int s);
        return s == 0 ? tmr_a_high_overflow_flag
             : s == 1 ? tmr_b_high_overflow_flag : tmr_b_low_overflow_flag;
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input int t, input logic [7:0] d);
        wr_en = 1'b1;
        wr_target = tmr_pkg::wr_target_t'(t);
        wr_data = d;
        step(1);
        wr_en = 1'b0;
        step(1);
    endtask

    task automatic wr16(input int base, input logic [15:0] v);
        wr(base, v[7:0]);
        wr(base + 1, v[15:8]);
    endtask

    task automatic clr();
        {tmr_a_flag_clear, tmr_b_high_flag_clear, tmr_b_low_flag_clear} = 3'h7;
        step(1);
        {tmr_a_flag_clear, tmr_b_high_flag_clear, tmr_b_low_flag_clear} = 3'h0;
    endtask

    task automatic wait_flag(input int s);
        int i;
        for (i = 0; i < 400 && flag(s) !== 1'b1; i++) step(1);
        check("overflow flag", 16'h0001, {15'h0000, flag(s)});
    endtask

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        {nrst, wr_en, wr_data, tmr_a_run, tmr_a_capture_enable, tmr_a_ext_clock_select,
         tmr_a_low_system_clock_select, tmr_a_irq_enable, tmr_a_flag_clear, tmr_b_run,
         tmr_b_split_mode, tmr_b_capture_enable, tmr_b_ext_clock_select,
         tmr_b_high_system_clock_select, tmr_b_low_system_clock_select, tmr_b_low_irq_enable,
         extended_irq_enable_one, tmr_b_high_flag_clear, tmr_b_low_flag_clear} = '0;
        wr_target = tmr_pkg::WR_A_CNT_L;
        ce = 1'b1;
        step(5);
        nrst = 1'b1;
        check("reset values", 16'h0000, cnt(0) | cnt(1) | rld(0) | rld(1));
        check("reset flags", 16'h0000, {flag(0), flag(1), flag(2), tmr_a_irq, tmr_b_irq});
        for (int t = 0; t < 8; t++) begin
            wr_data = rnd();
            c0 = wr_data;
            wr(t, c0[7:0]);
            c1 = t[1] ? rld(t[2]) : cnt(t[2]);
            check("written byte", c0, t[0] ? {8'h00, c1[15:8]} : {8'h00, c1[7:0]});
        end
        $display("test writes done");
        for (int s = 0; s < 5; s++) begin
            tmr_a_ext_clock_select = s[1:0];
            tmr_b_ext_clock_select = s[1:0];
            tmr_a_low_system_clock_select = (s == 4);
            tmr_b_low_system_clock_select = (s == 4);
            wr16(0, 16'h0000);
            wr16(4, 16'h0000);
            {tmr_a_run, tmr_b_run} = 2'h3;
            step(192);
            c0 = cnt(0);
            c1 = cnt(1);
            {tmr_a_run, tmr_b_run} = 2'h0;
            check("timer a source count", ea[s], c0);
            check("timer b source count", eb[s], c1);
        end
        $display("test clock sources done");
        {tmr_b_low_system_clock_select, extended_irq_enable_one} = 2'h3;
        r1 = {rnd(), 8'hF0};
        wr16(4, 16'hFEF8);
        wr16(6, r1);
        clr();
        tmr_b_run = 1'b1;
        wait_flag(2);
        check("low wrap without low irq", 16'h0000, {15'h0000, tmr_b_irq});
        wait_flag(1);
        check("16-bit reload", r1, cnt(1));
        check("full wrap irq", 16'h0001, {15'h0000, tmr_b_irq});
        clr();
        tmr_b_low_irq_enable = 1'b1;
        wait_flag(2);
        check("low wrap irq", 16'h0001, {15'h0000, tmr_b_irq});
        step(20);
        check("flag held", 16'h0001, {15'h0000, flag(2)});
        clr();
        check("flags cleared", 16'h0000, {flag(1), flag(2)});
        $display("test 16-bit wrap done");
        {tmr_b_run, tmr_b_low_irq_enable} = 2'h0;
        {tmr_b_split_mode, tmr_b_high_system_clock_select} = 2'h3;
        c1 = {rnd(), 8'h80};
        wr16(4, 16'hF8FC);
        wr16(6, c1);
        clr();
        wait_flag(2);
        check("low half reload", {8'h00, c1[7:0]}, {8'h00, tmr_b_count_low});
        check("high half held", 16'h00F8, {8'h00, tmr_b_count_high});
        check("low flag irq masked", 16'h0000, {flag(1), tmr_b_irq});
        tmr_b_low_irq_enable = 1'b1;
        step(2);
        check("low flag irq", 16'h0001, {15'h0000, tmr_b_irq});
        tmr_b_run = 1'b1;
        wait_flag(1);
        check("high half reload", {8'h00, c1[15:8]}, {8'h00, tmr_b_count_high});
        tmr_b_high_system_clock_select = 1'b0;
        tmr_b_ext_clock_select = 2'h0;
        c0 = {8'h00, tmr_b_count_high};
        step(96);
        for (int k = 0; k < 8; k++) begin
            c0 = (c0 == 16'h00FF) ? {8'h00, c1[15:8]} : c0 + 16'h0001;
        end
        check("high half div12", c0, {8'h00, tmr_b_count_high});
        $display("test split done");
        {tmr_b_run, tmr_b_split_mode, tmr_b_low_irq_enable} = 3'h0;
        {tmr_a_low_system_clock_select, tmr_b_low_system_clock_select, tmr_a_irq_enable} = 3'h7;
        for (int t = 0; t < 4; t++) begin
            tmr_a_ext_clock_select = {t[0], 1'b0};
            tmr_b_ext_clock_select = {t[0], 1'b0};
            wr16(t[1] ? 4 : 0, 16'h0000);
            {tmr_a_run, tmr_b_run} = 2'h3;
            {tmr_a_capture_enable, tmr_b_capture_enable} = t[1] ? 2'h1 : 2'h2;
            clr();
            wait_flag(t[1]);
            r1 = rld(t[1]);
            check("captured count", cnt(t[1]) - 16'h0001, r1);
            check("capture irq", 16'h0001, {15'h0000, t[1] ? tmr_b_irq : tmr_a_irq});
            clr();
            wait_flag(t[1]);
            caps.push_back(rld(t[1]) - r1);
            check("capture period", per[t], caps[t]);
            {tmr_a_capture_enable, tmr_b_capture_enable, tmr_a_run, tmr_b_run} = 4'h0;
        end
        $display("test capture done");
        tmr_b_run = 1'b1;
        ce = 1'b0;
        c1 = cnt(1);
        step(10);
        check("clock enable freeze", c1, cnt(1));
        ce = 1'b1;
        $display("test freeze done");
        finish_test();
    end
endmodule
